// ### rtl/mrw_pkg.sv
// Constants and types for the master reset and watchdog supervisor
package mrw_pkg;
  localparam int unsigned MRW_CLK_HZ = 125000000;
  localparam int unsigned MRW_TICK_HZ = 1008000;
  localparam int unsigned MRW_TICK_DIV = MRW_CLK_HZ / MRW_TICK_HZ;
  localparam int unsigned MRW_WDOG_S = 4;
  localparam int unsigned MRW_WDOG_TICKS = MRW_WDOG_S * MRW_TICK_HZ;
  localparam int unsigned MRW_EXT_MS = 100;
  localparam int unsigned MRW_EXT_TICKS = (MRW_EXT_MS * MRW_TICK_HZ + 999) / 1000;
  localparam int unsigned MRW_CNT_W = 24;
  localparam logic MRW_POWER_HOLD_RST = 1'b0;
  typedef enum logic [1:0] {MRW_RUN, MRW_PIN_HELD, MRW_EXTEND} mrw_state_type;
endpackage : mrw_pkg

// ### rtl/mrw_tick_if.sv
// Interface carrying the 1.008 MHz tick between modules
`timescale 1ns/1ps
interface mrw_tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : mrw_tick_if

// ### rtl/mrw_tick_gen.sv
// Divider producing the internal 1.008 MHz tick from the system clock
`timescale 1ns/1ps
module mrw_tick_gen
  import mrw_pkg::*;
#(
  parameter int unsigned DIV = MRW_TICK_DIV
)(
  input wire logic i_mclk,    // System clock
  input wire logic i_reset_n, // Async reset, active low
  mrw_tick_if.src tk          // Tick out
);
  logic [7:0] div_r;
  logic [7:0] div_nxt;

  // Refuse dividers that the 8-bit counter cannot serve
  if (DIV < 1 || DIV > 256)
  begin : g_div_chk
    $error("DIV out of range");
  end

  // Next divider value and tick
  always_comb
  begin
    tk.tick = (div_r == 8'(DIV - 1));
    div_nxt = tk.tick ? 8'h00 : div_r + 8'h01;
  end

  // Divider register
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      div_r <= 8'h00;
    else
      div_r <= div_nxt;
  end
endmodule : mrw_tick_gen

// ### rtl/mrw_watchdog.sv
// Master reset and watchdog supervisor top
`timescale 1ns/1ps
module mrw_watchdog
  import mrw_pkg::*;
#(
  parameter int unsigned WDOG_TICKS = MRW_WDOG_TICKS,
  parameter int unsigned EXT_TICKS = MRW_EXT_TICKS,
  parameter int unsigned TICK_DIV = MRW_TICK_DIV
)(
  input wire logic i_mclk,                  // System clock 125 MHz
  input wire logic i_reset_n,               // Power-on reset, active low
  input wire logic i_master_reset_in_n,     // Master reset pin, active low
  input wire logic i_service_mode_pin,      // Service mode, high active
  input wire logic i_watchdog_kick_reg,     // Write strobe to kick register
  input wire logic i_power_hold_set,        // Power hold request from logic
  output logic o_external_reset_out_n,      // External reset, active low
  output logic o_internal_reset_n,          // Reset to all internal logic
  output logic o_mode_select_load,          // Reapply processor mode select
  output logic o_power_hold_out_n,          // Power hold, active low
  output logic o_watchdog_timeout           // Timeout pulse
);
  import mrw_pkg::*;

  // Refuse spans that do not fit the counters
  if (WDOG_TICKS < 2 || WDOG_TICKS >= (1 << MRW_CNT_W))
  begin : g_wdog_chk
    $error("WDOG_TICKS out of range");
  end
  if (EXT_TICKS < 1 || EXT_TICKS >= (1 << MRW_CNT_W))
  begin : g_ext_chk
    $error("EXT_TICKS out of range");
  end

  mrw_tick_if tk ();

  mrw_tick_gen #(.DIV(TICK_DIV)) u_tick (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .tk(tk.src)
  );

  mrw_state_type state_r;
  mrw_state_type state_nxt;
  logic [MRW_CNT_W-1:0] wd_r;
  logic [MRW_CNT_W-1:0] wd_nxt;
  logic [MRW_CNT_W-1:0] ext_r;
  logic [MRW_CNT_W-1:0] ext_nxt;
  logic rst_out_r;
  logic rst_out_nxt;
  logic hold_r;
  logic hold_nxt;
  logic timeout;
  logic in_reset;

  // Overflow of the watchdog span
  // overflow detect
  assign timeout = (state_r == MRW_RUN) && tk.tick && (wd_r == MRW_CNT_W'(WDOG_TICKS - 1));
  assign o_watchdog_timeout = timeout;

  // Next state, counters and reset output
  always_comb
  begin
    state_nxt = state_r;
    wd_nxt = wd_r;
    ext_nxt = ext_r;
    rst_out_nxt = rst_out_r;
    case (state_r)
      MRW_RUN:
      begin
        if (!i_master_reset_in_n)
        begin
          state_nxt = MRW_PIN_HELD;
          wd_nxt = '0;
          rst_out_nxt = 1'b1;
        end
        else if (timeout)
        begin
          state_nxt = MRW_EXTEND;
          wd_nxt = '0;
          ext_nxt = '0;
          rst_out_nxt = 1'b1;
        end
        else if (i_service_mode_pin || i_watchdog_kick_reg)
          wd_nxt = '0;
        else if (tk.tick)
          wd_nxt = wd_r + 1'b1;
      end
      MRW_PIN_HELD:
      begin
        wd_nxt = '0;
        ext_nxt = '0;
        if (i_master_reset_in_n)
          state_nxt = MRW_EXTEND;
      end
      MRW_EXTEND:
      begin
        wd_nxt = '0;
        if (!i_master_reset_in_n)
          state_nxt = MRW_PIN_HELD;
        else if (tk.tick && ext_r == MRW_CNT_W'(EXT_TICKS - 1))
        begin
          state_nxt = MRW_RUN;
          rst_out_nxt = 1'b0;
        end
        else if (tk.tick)
          ext_nxt = ext_r + 1'b1;
      end
      default:
      begin
        state_nxt = MRW_RUN;
        rst_out_nxt = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_r <= MRW_EXTEND;
      wd_r <= '0;
      ext_r <= '0;
      rst_out_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      wd_r <= wd_nxt;
      ext_r <= ext_nxt;
      rst_out_r <= rst_out_nxt;
    end
  end

  // Reset outputs drop at once with the pin
  // asynchronous output drop
  assign in_reset = rst_out_r || !i_master_reset_in_n || !i_reset_n;
  assign o_external_reset_out_n = !in_reset;
  assign o_internal_reset_n = !in_reset;
  assign o_mode_select_load = in_reset;

  // Power hold ignores master reset, cleared only at power-on
  // power hold kept
  always_comb
  begin
    hold_nxt = hold_r | i_power_hold_set;
  end

  // Power hold register, cleared only at power-on
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      hold_r <= MRW_POWER_HOLD_RST;
    else
      hold_r <= hold_nxt;
  end
  assign o_power_hold_out_n = !hold_r;

  // Assertions
  a_timeout_resets: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    timeout |=> !o_external_reset_out_n) else $error("Timeout did not assert reset");
  a_pin_async_out: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !i_master_reset_in_n |-> !o_external_reset_out_n) else $error("Pin low but output high");
  a_wd_bounded: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    wd_r < MRW_CNT_W'(WDOG_TICKS)) else $error("Watchdog count beyond span");
  a_ext_min_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_external_reset_out_n) |-> state_r == MRW_RUN && $past(ext_r) == MRW_CNT_W'(EXT_TICKS - 1))
    else $error("Release before extension elapsed");
  a_hold_kept: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    timeout |=> $stable(o_power_hold_out_n) || !o_power_hold_out_n) else $error("Power hold dropped");
  a_service_mode_pin_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_service_mode_pin && state_r == MRW_RUN && i_master_reset_in_n |=> wd_r == '0)
    else $error("Service mode did not clear counter");
  a_pin_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !i_master_reset_in_n |=> wd_r == '0) else $error("Pin low did not clear counter");
  a_kick_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    i_watchdog_kick_reg |=> wd_r == '0) else $error("Kick did not clear counter");
  a_pin_extend: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(i_master_reset_in_n) |-> ##1 (state_r == MRW_EXTEND && ext_r == '0)) else $error("No extension after pin");
  a_mode_reload: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !o_internal_reset_n |-> o_mode_select_load) else $error("Mode select not reapplied");

  // Counter is held cleared whenever the state is not MRW_RUN
  a_wd_held_clear: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    state_r != MRW_RUN |-> wd_r == '0) else $error("Counter not cleared during reset");
  // Counter advances by exactly one on each tick while running
  a_count_step: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    state_r == MRW_RUN && tk.tick && i_master_reset_in_n && !i_service_mode_pin
    && !i_watchdog_kick_reg && !timeout |=> wd_r == $past(wd_r) + MRW_CNT_W'(1))
    else $error("Counter did not advance on tick");
  // Counter holds its value between ticks
  a_count_hold: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    state_r == MRW_RUN && !tk.tick && i_master_reset_in_n && !i_service_mode_pin
    && !i_watchdog_kick_reg |=> wd_r == $past(wd_r)) else $error("Counter moved without tick");
  // Overflow is a single-cycle pulse
  a_timeout_once: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    timeout |=> !timeout) else $error("Timeout pulse longer than one cycle");
  // Release only on a tick at the end of the extension
  a_release_sync: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_external_reset_out_n) |-> $past(state_r) == MRW_EXTEND && $past(tk.tick))
    else $error("Release not synchronous to tick");
  // Power hold never drops once set
  a_hold_sticky: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !o_power_hold_out_n |=> !o_power_hold_out_n) else $error("Power hold released");

  c_timeout: cover property (@(posedge i_mclk) disable iff (!i_reset_n) timeout);
  c_pin_reset: cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(i_master_reset_in_n));
  c_release: cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(o_external_reset_out_n));
  c_kick: cover property (@(posedge i_mclk) disable iff (!i_reset_n) i_watchdog_kick_reg && wd_r != '0);
  c_service: cover property (@(posedge i_mclk) disable iff (!i_reset_n) i_service_mode_pin && state_r == MRW_RUN);
endmodule : mrw_watchdog

// ### sim/mrw_rst_src.sv
// Model of the external source that drives the master reset pin
`timescale 1ns/1ps
module mrw_rst_src (
  input wire logic i_mclk,          // Clock, kept running
  input wire logic i_go,            // Start one low pulse
  input wire logic [7:0] i_low_len, // Pulse length in clocks
  output logic o_master_reset_in_n  // Master reset pin, active low
);
  logic [7:0] cnt_r = 8'h00;
  // Pin idles high until a pulse is asked for
  logic pin_r = 1'b1;
  assign o_master_reset_in_n = pin_r;
  // clock keeps running
  // Hold the pin low for the requested clocks while the clock runs on
  always @(posedge i_mclk)
  begin
    if (i_go)
    begin
      cnt_r <= i_low_len;
      pin_r <= 1'b0;
    end
    else if (cnt_r > 8'h01)
      cnt_r <= cnt_r - 8'h01;
    else
      pin_r <= 1'b1;
  end
endmodule : mrw_rst_src

// ### sim/master_reset_watchdog_tb.sv
// Self-checking bench for the reset and watchdog supervisor
`timescale 1ns/1ps
module master_reset_watchdog_tb;
  import mrw_pkg::*;
  localparam int WD = 20;
  localparam int EX = 5;
  localparam int DV = 2;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_service_mode_pin = 1'b0;
  logic i_watchdog_kick_reg = 1'b0;
  logic i_power_hold_set = 1'b0;
  logic go = 1'b0;
  logic [7:0] low_len = 8'h00;
  logic pin_n, ext_n, int_n, mode_ld, hold_n, wd_to;
  int n_mismatch = 0;
  int cmp_count = 0;
  int exp_q[$];
  int low_cnt = 0;
  int e;
  logic [31:0] rnd = 32'h271f172b;
  mrw_watchdog #(.WDOG_TICKS(WD), .EXT_TICKS(EX), .TICK_DIV(DV)) i_mrw_watchdog (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_master_reset_in_n(pin_n), .i_service_mode_pin(i_service_mode_pin),
    .i_watchdog_kick_reg(i_watchdog_kick_reg), .i_power_hold_set(i_power_hold_set),
    .o_external_reset_out_n(ext_n), .o_internal_reset_n(int_n), .o_mode_select_load(mode_ld),
    .o_power_hold_out_n(hold_n), .o_watchdog_timeout(wd_to));
  mrw_rst_src i_mrw_rst_src (.i_mclk(i_mclk), .i_go(go), .i_low_len(low_len), .o_master_reset_in_n(pin_n));
  // Free-running clock
  initial
  begin
    forever #4 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    cmp_count++;
    if ($isunknown(got) || $isunknown(lo) || $isunknown(hi) || got < lo || got > hi)
    begin
      n_mismatch++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : check
  task automatic test_done;
    $display("Compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  // Monitor at mid-cycle, where outputs have settled: match each reset episode to the oldest note
  always @(negedge i_mclk)
  begin
    check("internal reset", ext_n, ext_n, int_n);
    check("mode select load", !ext_n, !ext_n, mode_ld);
    if (ext_n === 1'b0)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      e = (exp_q.size() == 0) ? 0 : exp_q.pop_front();
      check("reset low length", e, (e == 0) ? 0 : e + 4, low_cnt);
      low_cnt <= 0;
    end
  end
  // Watchdog on the whole run
  initial
  begin
    #200000;
    n_mismatch++;
    test_done();
  end
  // Main sequence
  initial
  begin
    int t;
    exp_q.push_back(EX * DV);
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    #1 check("power hold idle", 1, 1, hold_n);
    repeat (20) @(posedge i_mclk);
    // Pin pulses, the last one longer than the watchdog span
    for (int k = 0; k < 3; k++)
    begin
      rnd = lfsr(rnd);
      t = (k == 2) ? 60 : 2 + rnd[3:0];
      exp_q.push_back(t + EX * DV);
      go <= 1'b1;
      low_len <= t[7:0];
      @(posedge i_mclk);
      go <= 1'b0;
      #1 check("async reset out", 0, 0, ext_n);
      repeat (t + 30) @(posedge i_mclk);
    end
    // Random kicks well inside the span
    for (int k = 0; k < 20; k++)
    begin
      i_watchdog_kick_reg <= 1'b1;
      @(posedge i_mclk);
      i_watchdog_kick_reg <= 1'b0;
      rnd = lfsr(rnd);
      repeat (8 + rnd[3:0]) @(posedge i_mclk);
    end
    i_service_mode_pin <= 1'b1;
    repeat (150) @(posedge i_mclk);
    // Leave service mode, set power hold once, stop kicking
    i_service_mode_pin <= 1'b0;
    i_power_hold_set <= 1'b1;
    exp_q.push_back(EX * DV);
    @(posedge i_mclk);
    i_power_hold_set <= 1'b0;
    t = 1;
    while (wd_to !== 1'b1 && t < 100)
    begin
      @(posedge i_mclk);
      #1 t++;
    end
    check("timeout span", WD * DV - 3, WD * DV + 4, t);
    repeat (30) @(posedge i_mclk);
    #1 check("power hold kept", 0, 0, hold_n);
    check("episodes pending", 0, 0, exp_q.size());
    test_done();
  end
endmodule : master_reset_watchdog_tb
